//--- core/alu_working_register_datapath.sv
// Fetch pipeline, 8-bit ALU, working accumulator and status flags.
// Assumes program memory answers a word in the same phase it is addressed,
// and the register file answers a read combinationally on its own data bus.
//
// Functional notes
// - Every instruction is one 12-bit word
// - One whole instruction fetched per cycle
// - Program and data buses are separate
// - Fetch of next overlaps current execute
// - One cycle each, flow changes take more
// - Program memory on chip, 512 or 1K
// - Special registers, pointer included, data-mapped
// - Registers reachable directly and indirectly
// - Any operation on any register
// - ALU is 8 bits: add, sub, shift, logic
// - Arithmetic is two's complement
// - Accumulator plus file register or literal
// - Single operand is a register; result to accumulator or register
// - Accumulator is 8-bit, not data-mapped
// - ALU updates carry, digit carry, zero
// - Subtract: carry means no borrow
// - Four phases; read second, write fourth
// - Pointer change flushes, takes two cycles
`timescale 1ns/1ns
`default_nettype none
`include "awrd_regs.svh"

module alu_working_register_datapath
   import awrd_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b0
)
(
   input wire logic ref_clk,
   input wire logic reset,
   output logic [`AWRD_PTR_W-1:0] progAddr,
   input wire logic [`AWRD_INSN_W-1:0] progData,
   output logic [`AWRD_ADDR_W-1:0] dataAddr,
   input wire logic [`AWRD_DATA_W-1:0] dataRd,
   output logic [`AWRD_DATA_W-1:0] dataWr,
   output logic dataRdEn,
   output logic dataWrEn,
   output logic [`AWRD_DATA_W-1:0] workAcc,
   output logic carryFlag,
   output logic digit_carry_flag,
   output logic zeroFlag,
   output logic [`AWRD_PTR_W-1:0] instruction_pointer,
   output logic [3:0] phase
);
   localparam logic [`AWRD_PTR_W-1:0] PTR_MASK =
      LARGE_VARIANT ? `AWRD_PTR_MASK_LARGE : `AWRD_PTR_MASK_SMALL;

   typedef struct packed
   {
      awrd_phase_t ph;
      logic [`AWRD_PTR_W-1:0] ptr;
      logic [`AWRD_INSN_W-1:0] fetched;
      logic [`AWRD_INSN_W-1:0] ir;
      logic flush;
      logic [`AWRD_DATA_W-1:0] w;
      logic [`AWRD_DATA_W-1:0] fsr;
      logic [`AWRD_DATA_W-1:0] opnd;
      logic [`AWRD_DATA_W-1:0] res;
      logic resToFile;
      logic resToW;
      logic [`AWRD_ADDR_W-1:0] addr;
      logic c;
      logic digit;
      logic z;
      logic rdEn;
      logic wrEn;
      logic [`AWRD_DATA_W-1:0] wrData;
   } awrd_state_t;

   awrd_state_t st;
   awrd_state_t next_st;

   // Decode of the instruction in execute
   awrd_op_t op;
   logic useLit;
   logic destFile;
   logic setsC;
   logic setsDigit;
   logic setsZ;
   logic [`AWRD_ADDR_W-1:0] fileField;
   logic [`AWRD_DATA_W-1:0] litField;
   logic [`AWRD_DATA_W-1:0] aOp;
   logic [`AWRD_DATA_W-1:0] bOp;
   logic [`AWRD_DATA_W:0] sum;
   logic [4:0] nib;
   logic [`AWRD_DATA_W-1:0] aluOut;
   logic aluC;
   logic aluDigit;

   // Opcode layout: [11] literal flag, [10:8] literal op or [9:6] file op, [5] dest, [4:0] file or [7:0] literal
   always_comb
   begin
      fileField = st.ir[`AWRD_ADDR_W-1:0];
      litField = st.ir[`AWRD_DATA_W-1:0];
      destFile = st.ir[5];
      useLit = st.ir[11];
      op = AWRD_OP_NOP;
      if (st.ir[11])
      begin
         case (st.ir[10:8])
            3'h0: op = AWRD_OP_MWL;
            3'h1: op = AWRD_OP_IOR;
            3'h2: op = AWRD_OP_AND;
            3'h3: op = AWRD_OP_XOR;
            3'h4: op = AWRD_OP_ADD;
            3'h5: op = AWRD_OP_SUB;
            3'h6: op = AWRD_OP_GTO;
            default: op = AWRD_OP_GTO;
         endcase
      end
      else if (st.ir[10:6] != 5'h00)
      begin
         op = awrd_op_t'(st.ir[9:6]);
      end
      setsC = op inside {AWRD_OP_ADD, AWRD_OP_SUB, AWRD_OP_RLF, AWRD_OP_RRF};
      setsDigit = op inside {AWRD_OP_ADD, AWRD_OP_SUB};
      setsZ = !(op inside {AWRD_OP_NOP, AWRD_OP_MOV, AWRD_OP_MWL, AWRD_OP_GTO,
                           AWRD_OP_RLF, AWRD_OP_RRF, AWRD_OP_SWP});
   end

   // ALU: accumulator against file operand or literal
   always_comb
   begin
      aOp = st.w;
      bOp = useLit ? litField : st.opnd;
      sum = '0;
      nib = '0;
      aluOut = '0;
      aluC = st.c;
      aluDigit = st.digit;
      case (op)
         AWRD_OP_ADD:
         begin
            sum = {1'b0, bOp} + {1'b0, aOp};
            nib = {1'b0, bOp[3:0]} + {1'b0, aOp[3:0]};
            aluOut = sum[`AWRD_DATA_W-1:0];
            aluC = sum[`AWRD_DATA_W];
            aluDigit = nib[4];
         end
         AWRD_OP_SUB:
         begin
            // Two's complement: b + ~a + 1; carry high means no borrow
            sum = {1'b0, bOp} + {1'b0, ~aOp} + 9'h001;
            nib = {1'b0, bOp[3:0]} + {1'b0, ~aOp[3:0]} + 5'h01;
            aluOut = sum[`AWRD_DATA_W-1:0];
            aluC = sum[`AWRD_DATA_W];
            aluDigit = nib[4];
         end
         AWRD_OP_AND: aluOut = aOp & bOp;
         AWRD_OP_IOR: aluOut = aOp | bOp;
         AWRD_OP_XOR: aluOut = aOp ^ bOp;
         AWRD_OP_MOV: aluOut = bOp;
         AWRD_OP_MWL: aluOut = litField;
         AWRD_OP_COM: aluOut = ~bOp;
         AWRD_OP_INC: aluOut = bOp + 8'h01;
         AWRD_OP_DEC: aluOut = bOp - 8'h01;
         AWRD_OP_RLF:
         begin
            aluOut = {bOp[`AWRD_DATA_W-2:0], st.c};
            aluC = bOp[`AWRD_DATA_W-1];
         end
         AWRD_OP_RRF:
         begin
            aluOut = {st.c, bOp[`AWRD_DATA_W-1:1]};
            aluC = bOp[0];
         end
         AWRD_OP_CLR: aluOut = 8'h00;
         AWRD_OP_SWP: aluOut = {bOp[3:0], bOp[7:4]};
         default: aluOut = aOp;
      endcase
   end

   always_comb
   begin
      next_st = st;
      next_st.rdEn = 1'b0;
      next_st.wrEn = 1'b0;
      case (st.ph)
         AWRD_FIRST_PHASE:
         begin
            // Latch fetched word; flushed slot runs as no-op
            next_st.ir = st.flush ? 12'h000 : st.fetched;
            next_st.flush = 1'b0;
            // A flushed slot keeps the pointer, so the reset or branch target is fetched next
            if (st.flush)
            begin
               next_st.ptr = st.ptr;
            end
            else
            begin
               next_st.ptr = (st.ptr + 10'h001) & PTR_MASK;
            end
            next_st.ph = AWRD_SECOND_PHASE;
         end
         AWRD_SECOND_PHASE:
         begin
            // Indirect access goes through the select register
            next_st.addr = (fileField == `AWRD_INDF_ADDR) ?
               st.fsr[`AWRD_ADDR_W-1:0] : fileField;
            // Literal ops and no-ops leave the data bus idle
            next_st.rdEn = !useLit && op != AWRD_OP_NOP;
            next_st.ph = AWRD_THIRD_PHASE;
         end
         AWRD_THIRD_PHASE:
         begin
            if (st.addr == `AWRD_STATUS_ADDR)
            begin
               next_st.opnd = {dataRd[7:3], st.z, st.digit, st.c};
            end
            else if (st.addr == `AWRD_FSR_ADDR)
            begin
               next_st.opnd = st.fsr;
            end
            else if (st.addr == `AWRD_PCL_ADDR)
            begin
               next_st.opnd = st.ptr[`AWRD_DATA_W-1:0];
            end
            else
            begin
               next_st.opnd = dataRd;
            end
            next_st.ph = AWRD_FOURTH_PHASE;
         end
         AWRD_FOURTH_PHASE:
         begin
            next_st.fetched = progData;
            next_st.res = aluOut;
            next_st.resToFile = destFile && !useLit && op != AWRD_OP_NOP;
            next_st.resToW = (useLit || !destFile) && op != AWRD_OP_NOP && op != AWRD_OP_GTO;
            if (setsC)
            begin
               next_st.c = aluC;
            end
            if (setsDigit)
            begin
               next_st.digit = aluDigit;
            end
            if (setsZ)
            begin
               next_st.z = (aluOut == 8'h00);
            end
            if (op == AWRD_OP_GTO)
            begin
               next_st.ptr = {2'b00, litField} & PTR_MASK;
               next_st.flush = 1'b1;
            end
            if (destFile && !useLit && op != AWRD_OP_NOP)
            begin
               next_st.wrEn = 1'b1;
               next_st.wrData = aluOut;
               if (st.addr == `AWRD_FSR_ADDR)
               begin
                  next_st.fsr = aluOut;
               end
               if (st.addr == `AWRD_PCL_ADDR)
               begin
                  next_st.ptr = {st.ptr[`AWRD_PTR_W-1:`AWRD_DATA_W], aluOut} & PTR_MASK;
                  next_st.flush = 1'b1;
               end
            end
            else if (next_st.resToW)
            begin
               next_st.w = aluOut;
            end
            next_st.ph = AWRD_FIRST_PHASE;
         end
         default: next_st.ph = AWRD_FIRST_PHASE;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         st <= '0;
         st.ph <= AWRD_FIRST_PHASE;
         st.ptr <= `AWRD_PTR_RESET;
         st.w <= `AWRD_W_RESET;
         st.flush <= 1'b1;
      end
      else
      begin
         st <= next_st;
      end
   end

   always_comb
   begin
      progAddr = st.ptr;
      dataAddr = st.addr;
      dataWr = st.wrData;
      dataRdEn = st.rdEn;
      dataWrEn = st.wrEn;
      workAcc = st.w;
      carryFlag = st.c;
      digit_carry_flag = st.digit;
      zeroFlag = st.z;
      instruction_pointer = st.ptr;
      phase = st.ph;
   end

   AST_PHASE_ROTATES: assert property (@(posedge ref_clk) disable iff (reset)
      st.ph == AWRD_FIRST_PHASE |=> st.ph == AWRD_SECOND_PHASE ##1 st.ph == AWRD_THIRD_PHASE
      ##1 st.ph == AWRD_FOURTH_PHASE)
      else $error("phase sequence broken");
   AST_READ_SECOND: assert property (@(posedge ref_clk) disable iff (reset)
      dataRdEn |-> $past(st.ph) == AWRD_SECOND_PHASE)
      else $error("data read outside second phase");
   AST_WRITE_FOURTH: assert property (@(posedge ref_clk) disable iff (reset)
      dataWrEn |-> $past(st.ph) == AWRD_FOURTH_PHASE)
      else $error("data write outside fourth phase");
   AST_PTR_STEP: assert property (@(posedge ref_clk) disable iff (reset)
      st.ph == AWRD_FIRST_PHASE && !st.flush |=> st.ptr == (($past(st.ptr) + 10'h001) & PTR_MASK))
      else $error("pointer did not advance");
   AST_PTR_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
      st.ph == AWRD_FIRST_PHASE && st.flush |=> st.ptr == $past(st.ptr))
      else $error("pointer moved in flushed slot");
   AST_ZERO_FLAG: assert property (@(posedge ref_clk) disable iff (reset)
      st.ph == AWRD_FOURTH_PHASE && setsZ && !(destFile && !useLit) |=> zeroFlag == (workAcc == 8'h00))
      else $error("zero flag mismatch");
   AST_ZERO_FILE: assert property (@(posedge ref_clk) disable iff (reset)
      st.ph == AWRD_FOURTH_PHASE && setsZ && destFile && !useLit |=> zeroFlag == (dataWr == 8'h00))
      else $error("zero flag mismatch on file result");
   AST_FLUSH: assert property (@(posedge ref_clk) disable iff (reset)
      st.ph == AWRD_FOURTH_PHASE && op == AWRD_OP_GTO |-> ##1 st.ph == AWRD_FIRST_PHASE ##1 st.ir == 12'h000)
      else $error("branch did not flush");
   AST_SUB_BORROW: assert property (@(posedge ref_clk) disable iff (reset)
      st.ph == AWRD_FOURTH_PHASE && op == AWRD_OP_SUB |=> carryFlag == ($past(bOp) >= $past(st.w)))
      else $error("borrow flag wrong");
   AST_W_HOLD: assert property (@(posedge ref_clk) disable iff (reset)
      st.ph != AWRD_FOURTH_PHASE |=> workAcc == $past(workAcc))
      else $error("accumulator changed outside fourth phase");
   AST_FETCH_LATCH: assert property (@(posedge ref_clk) disable iff (reset)
      st.ph == AWRD_FOURTH_PHASE |=> st.fetched == $past(progData))
      else $error("fetch not latched");
   COV_ADD: cover property (@(posedge ref_clk) st.ph == AWRD_FOURTH_PHASE && op == AWRD_OP_ADD && aluC);
   COV_SUB: cover property (@(posedge ref_clk) st.ph == AWRD_FOURTH_PHASE && op == AWRD_OP_SUB && !aluC);
   COV_BRANCH: cover property (@(posedge ref_clk) st.ph == AWRD_FOURTH_PHASE && op == AWRD_OP_GTO);
   COV_INDIRECT: cover property (@(posedge ref_clk) st.ph == AWRD_SECOND_PHASE && fileField == `AWRD_INDF_ADDR);
   COV_FILE_WRITE: cover property (@(posedge ref_clk) st.ph == AWRD_FOURTH_PHASE && destFile && !useLit);
endmodule
`default_nettype wire

//--- include/awrd_regs.svh
// Constants for the ALU and working register datapath.
// Assumes inclusion by the core, memory model and bench; definitions only.
`ifndef AWRD_REGS_SVH
`define AWRD_REGS_SVH
`define AWRD_INSN_W 12
`define AWRD_DATA_W 8
`define AWRD_ADDR_W 5
`define AWRD_PTR_W 10
`define AWRD_PTR_MASK_SMALL 10'h1FF
`define AWRD_PTR_MASK_LARGE 10'h3FF
`define AWRD_PTR_RESET 10'h000
`define AWRD_W_RESET 8'h00
`define AWRD_INDF_ADDR 5'h00
`define AWRD_PCL_ADDR 5'h02
`define AWRD_STATUS_ADDR 5'h03
`define AWRD_FSR_ADDR 5'h04
`define AWRD_FLAG_C 0
`define AWRD_FLAG_DIGIT 1
`define AWRD_FLAG_Z 2
`define AWRD_PHASE_CYCLE_NS 400
`define AWRD_CLK_NS 100
`define AWRD_PHASES (`AWRD_PHASE_CYCLE_NS / `AWRD_CLK_NS)
`endif

//--- include/awrd_pkg.sv
// Types for the ALU and working register datapath.
// Assumes awrd_regs.svh widths.
package awrd_pkg;
   typedef enum logic [3:0]
   {
      AWRD_FIRST_PHASE = 4'h1,
      AWRD_SECOND_PHASE = 4'h2,
      AWRD_THIRD_PHASE = 4'h4,
      AWRD_FOURTH_PHASE = 4'h8
   } awrd_phase_t;

   // Operation class decoded from the low-level opcode fields
   typedef enum logic [3:0]
   {
      AWRD_OP_NOP = 4'h0,
      AWRD_OP_ADD = 4'h1,
      AWRD_OP_SUB = 4'h2,
      AWRD_OP_AND = 4'h3,
      AWRD_OP_IOR = 4'h4,
      AWRD_OP_XOR = 4'h5,
      AWRD_OP_MOV = 4'h6,
      AWRD_OP_COM = 4'h7,
      AWRD_OP_INC = 4'h8,
      AWRD_OP_DEC = 4'h9,
      AWRD_OP_RLF = 4'hA,
      AWRD_OP_RRF = 4'hB,
      AWRD_OP_CLR = 4'hC,
      AWRD_OP_SWP = 4'hD,
      AWRD_OP_GTO = 4'hE,
      AWRD_OP_MWL = 4'hF
   } awrd_op_t;
endpackage

//--- verification/awrd_mem_model.sv
// Program memory and data register file seen from the datapath.
// Assumes the datapath reads both combinationally and writes on its strobe.
`timescale 1ns/1ns
`default_nettype none
`include "awrd_regs.svh"

module awrd_mem_model
(
   input wire logic ref_clk,
   input wire logic [`AWRD_PTR_W-1:0] progAddr,
   output logic [`AWRD_INSN_W-1:0] progData,
   input wire logic [`AWRD_ADDR_W-1:0] dataAddr,
   input wire logic dataRdEn,
   input wire logic dataWrEn,
   input wire logic [`AWRD_DATA_W-1:0] dataWr,
   output logic [`AWRD_DATA_W-1:0] dataRd
);
   logic [`AWRD_INSN_W-1:0] prog [0:1023];
   logic [`AWRD_DATA_W-1:0] regs [0:31];
   logic [`AWRD_DATA_W-1:0] lastRd = 8'h00;

   // Own bus per memory so fetch and file access overlap
   assign progData = prog[progAddr];
   // Unselected read bus shows no stale value
   assign dataRd = dataRdEn ? regs[dataAddr] : ~lastRd;

   always @(posedge ref_clk)
   begin
      if (dataRdEn)
      begin
         lastRd <= regs[dataAddr];
      end
      if (dataWrEn)
      begin
         regs[dataAddr] <= dataWr;
      end
   end
endmodule
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the ALU and working register datapath.
// Assumes the memory model answers fetches and file reads at once.
`timescale 1ns/1ns
`default_nettype none
`include "awrd_regs.svh"

module tb;
   import awrd_pkg::*;
   typedef struct {logic [11:0] insn; logic [7:0] w; logic [2:0] zdc;} awrd_row_t;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [9:0] progAddr;
   logic [11:0] progData;
   logic [4:0] dataAddr;
   logic [7:0] dataRd;
   logic [7:0] dataWr;
   logic dataRdEn;
   logic dataWrEn;
   logic [7:0] workAcc;
   logic carryFlag;
   logic digit_carry_flag;
   logic zeroFlag;
   logic [9:0] instructionPtr;
   logic [3:0] phase;
   int mismatches = 0;
   int tests_run = 0;
   int cycles = 0;
   int rdCount = 0;
   int wrCount = 0;
   awrd_row_t rows [8] = '{
      '{12'h80F, 8'h0F, 3'b000}, '{12'hC01, 8'h10, 3'b010}, '{12'hCF0, 8'h00, 3'b101},
      '{12'h9A5, 8'hA5, 3'b001}, '{12'hA5A, 8'h00, 3'b101}, '{12'hBFF, 8'hFF, 3'b001},
      '{12'hD01, 8'h02, 3'b000}, '{12'hD02, 8'h00, 3'b111}};
   logic [11:0] prog2 [8] = '{12'h881, 12'h070, 12'h090, 12'hE06, 12'h8EE, 12'h8DD, 12'h833, 12'hE07};
   logic [7:0] expW2 [6] = '{8'h81, 8'h81, 8'h7F, 8'h7F, 8'h7F, 8'h33};

   alu_working_register_datapath DUT (.ref_clk(ref_clk), .reset(reset), .progAddr(progAddr),
      .progData(progData), .dataAddr(dataAddr), .dataRd(dataRd), .dataWr(dataWr),
      .dataRdEn(dataRdEn), .dataWrEn(dataWrEn), .workAcc(workAcc), .carryFlag(carryFlag),
      .digit_carry_flag(digit_carry_flag), .zeroFlag(zeroFlag),
      .instruction_pointer(instructionPtr), .phase(phase));

   awrd_mem_model mem (.ref_clk(ref_clk), .progAddr(progAddr), .progData(progData),
      .dataAddr(dataAddr), .dataRdEn(dataRdEn), .dataWrEn(dataWrEn), .dataWr(dataWr),
      .dataRd(dataRd));

   always #50 ref_clk = ~ref_clk;

   task complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
      begin
         $display("NO MISMATCHES");
      end
      else
      begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 400)
      begin
         mismatches++;
         complete_run();
      end
   end

   // Strobes are one-cycle pulses, so each is seen at one falling edge
   always @(negedge ref_clk)
   begin
      if (dataRdEn === 1'b1)
      begin
         rdCount++;
      end
      if (dataWrEn === 1'b1)
      begin
         wrCount++;
      end
   end

   task check(input logic [7:0] got, input logic [7:0] exp, input string what);
      tests_run++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task do_reset;
      @(negedge ref_clk);
      reset = 1'b1;
      repeat (2) @(negedge ref_clk);
      check(workAcc, 8'h00, "acc in reset");
      check({4'h0, phase}, {4'h0, AWRD_FIRST_PHASE}, "phase in reset");
      check({5'h00, zeroFlag, digit_carry_flag, carryFlag}, 8'h00, "flags in reset");
      check(instructionPtr[7:0], 8'h00, "pointer in reset");
      rdCount = 0;
      wrCount = 0;
      reset = 1'b0;
   endtask

   // Moves to the next second phase, one instruction slot later
   task next_read_phase;
      int n;
      n = 0;
      do
      begin
         @(negedge ref_clk);
         n++;
      end
      while (phase !== AWRD_SECOND_PHASE && n < 8);
   endtask

   initial
   begin
      for (int i = 0; i < 8; i++)
      begin
         mem.prog[i] = rows[i].insn;
      end
      mem.prog[8] = 12'hE08;
      do_reset();
      next_read_phase();
      next_read_phase();
      // Literal program: one result per cycle, flags as the ALU defines
      for (int i = 0; i < 8; i++)
      begin
         next_read_phase();
         check(workAcc, rows[i].w, "acc literal op");
         check({5'h00, zeroFlag, digit_carry_flag, carryFlag}, {5'h00, rows[i].zdc}, "flags");
      end
      check(8'(rdCount + wrCount), 8'h00, "file access on literal ops");
      // File operand add, subtract back into acc, then a jump over two words
      for (int i = 0; i < 8; i++)
      begin
         mem.prog[i] = prog2[i];
      end
      mem.regs[16] = 8'h7F;
      do_reset();
      next_read_phase();
      next_read_phase();
      for (int i = 0; i < 6; i++)
      begin
         next_read_phase();
         check(workAcc, expW2[i], "acc after file op or jump");
         if (i == 1)
         begin
            check({5'h00, zeroFlag, digit_carry_flag, carryFlag}, 8'h07, "add carry flags");
            check({3'h0, dataAddr}, 8'h10, "file address");
         end
         if (i == 3)
         begin
            check(instructionPtr[7:0], 8'h06, "pointer held after jump");
            check(progAddr[7:0], 8'h06, "fetch address after jump");
         end
         if (i == 2)
         begin
            check({5'h00, zeroFlag, digit_carry_flag, carryFlag}, 8'h00, "sub borrow flags");
         end
      end
      check(mem.regs[16], 8'h00, "file result");
      check(8'(rdCount), 8'h02, "file reads");
      check(8'(wrCount), 8'h01, "file writes");
      complete_run();
   end
endmodule
`default_nettype wire
